// File: rtl/dbs_pkg.sv
// Package with command encodings, latency and timing constants for the burst sequencer.
package dbs_pkg;

  // Command encodings as seen on the command inputs (cs_n, ras_n, cas_n, we_n).
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_RD    = 4'h5;
  localparam logic [3:0] CMD_WR    = 4'h4;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_DESEL = 4'h8;

  // Bank count and bank address width.
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned BANK_W    = 2;

  // Burst length choices.
  localparam logic [3:0] BL_FOUR  = 4'h4;
  localparam logic [3:0] BL_EIGHT = 4'h8;

  // Default latencies in clocks.
  localparam logic [3:0] AL_DEFAULT = 4'h2;
  localparam logic [3:0] CL_DEFAULT = 4'h3;

  // Clock period and self refresh exit delays.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TXSRD_CLK     = 200;
  localparam int unsigned TXSNR_NS      = 200;
  localparam int unsigned TXSNR_CYC     = (TXSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Pipeline depth of the latency shift line.
  localparam int unsigned LAT_DEPTH = 16;

  // Sequencer states, Gray coded from active through self refresh to exit.
  typedef enum logic [1:0] {
    DBS_ACTIVE = 2'b00,
    DBS_SREF   = 2'b01,
    DBS_EXIT   = 2'b11
  } dbs_state_t;

  // Read latency is additive plus CAS latency.
  function automatic logic [4:0] dbs_read_lat(input logic [3:0] al, input logic [3:0] cl);
    dbs_read_lat = {1'b0, al} + {1'b0, cl};
  endfunction : dbs_read_lat

endpackage : dbs_pkg

// File: rtl/dbs_fifo_if.sv
// Interface carrying a valid and ready word stream between the sequencer and its FIFO.
`timescale 1ns/1ns
`default_nettype none
interface dbs_fifo_if #(parameter int unsigned WIDTH = 16);
  logic             valid;  // Word offered.
  logic             ready;  // Word taken.
  logic [WIDTH-1:0] data;   // Word payload.
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dbs_fifo_if
`default_nettype wire

// File: rtl/dbs_fifo.sv
// Synchronous FIFO with parameter width and depth, read data from a register.
`timescale 1ns/1ns
`default_nettype none
module dbs_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset.
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  // Fill and drain sides.
  dbs_fifo_if.snk   wr,
  dbs_fifo_if.src   rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  // Depth must be a power of two of at least two.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dbs_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
  logic [AW:0]      wptr;         // Write pointer with wrap bit.
  logic [AW:0]      rptr;         // Read pointer with wrap bit.
  logic [WIDTH-1:0] rdata;        // Registered head word.
  logic             rvalid;       // Head register holds a word.
  logic             full;         // No room left.
  logic             empty;        // Nothing in storage.
  logic             pull;         // Move one word into the head register.

  assign full     = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty    = (wptr == rptr);
  assign wr.ready = !full;
  assign pull     = !empty && (!rvalid || rd.ready);
  assign rd.valid = rvalid;
  assign rd.data  = rdata;

  // Store a word when offered and there is room.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wptr <= '0;
    end else if (wr.valid && !full) begin
      mem[wptr[AW-1:0]] <= wr.data;
      wptr              <= wptr + 1'b1;
    end
  end

  // Refill the head register whenever it is free or being drained.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rptr   <= '0;
      rvalid <= 1'b0;
      rdata  <= '0;
    end else if (pull) begin
      rdata  <= mem[rptr[AW-1:0]];
      rptr   <= rptr + 1'b1;
      rvalid <= 1'b1;
    end else if (rd.ready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : dbs_fifo
`default_nettype wire

// File: rtl/dbs_seq.sv
// Device side burst and self refresh sequencer of a DDR2 style memory.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Seamless reads every 2 or 4 clocks
// - Seamless writes every 2 or 4 clocks
// - Bursts need an activated bank, any bank
// - Read latency is additive plus CAS
// - Write latency is read latency minus one
// - Strobe mode bit picks single or differential
module dbs_seq
  import dbs_pkg::*;
#(
  parameter int unsigned DQ_W      = 16,
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned XSRD_CYC  = TXSRD_CLK
) (
  // Clock and reset.
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  // Command bus.
  input  wire logic              cke_i,
  input  wire logic [3:0]        cmd_i,
  input  wire logic [BANK_W-1:0] bank_i,
  input  wire logic              odt_i,
  // Mode settings.
  input  wire logic [3:0]        al_i,
  input  wire logic [3:0]        cl_i,
  input  wire logic              bl8_i,
  input  wire logic              dqs_diff_en_i,
  // Write data in.
  input  wire logic [DQ_W-1:0]   wdata_i,
  output logic                   wdata_ready_o,
  // Write data out to array side.
  output logic                   wr_valid_o,
  output logic [DQ_W-1:0]        wr_data_o,
  input  wire logic              wr_ready_i,
  // Read data path.
  input  wire logic [DQ_W-1:0]   array_rdata_i,
  output logic [DQ_W-1:0]        rdata_o,
  output logic                   rdata_valid_o,
  // Strobe outputs.
  output logic                   dqs_o,
  output logic                   dqs_n_o,
  output logic                   dqs_oe_o,
  // Status.
  output logic                   sref_o,
  output logic                   odt_active_o,
  output logic                   cmd_err_o
);

  // Parameters the logic cannot serve are refused.
  // The exit counter is sixteen bits wide, so the long exit delay must fit in it.
  if (DQ_W < 1 || XSRD_CYC < TXSNR_CYC || XSRD_CYC > 32'h0000ffff) begin : g_bad_param
    $error("dbs_seq parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  ////////////////////////////////////////////////////////////////////////////////

  dbs_state_t           state;        // Self refresh state.
  logic [NUM_BANKS-1:0] bank_open;    // Open banks.
  logic [LAT_DEPTH-1:0] rd_line;      // Read beat scheduling line.
  logic [LAT_DEPTH-1:0] wr_line;      // Write beat scheduling line.
  logic [4:0]           rl;           // Read latency.
  logic [4:0]           wl;           // Write latency.
  logic [3:0]           beats;        // Beats per burst on the internal clock.
  logic [15:0]          exit_cnt;     // Clocks since the self refresh exit edge.
  logic                 rd_cmd;       // Read command decoded.
  logic                 wr_cmd;       // Write command decoded.
  logic                 bad_cmd;      // Command breaks a sequencing condition.
  logic [LAT_DEPTH-1:0] next_rd_line; // Next read line.
  logic [LAT_DEPTH-1:0] next_wr_line; // Next write line.

  dbs_fifo_if #(.WIDTH(DQ_W)) f_in ();
  dbs_fifo_if #(.WIDTH(DQ_W)) f_out ();

  ////////////////////////////////////////////////////////////////////////////////
  // Latency and command decode.
  ////////////////////////////////////////////////////////////////////////////////

  assign rl = dbs_read_lat(al_i, cl_i);
  assign wl = rl - 5'h01;
  // Beats per burst; two data words per clock, so half the burst length.
  assign beats = bl8_i ? (BL_EIGHT >> 1) : (BL_FOUR >> 1);

  // Reads and writes are taken when active, or once their exit delay has run out.
  assign rd_cmd = cke_i && (cmd_i == CMD_RD) && (state == DBS_ACTIVE
                  || (state == DBS_EXIT && exit_cnt >= 16'(XSRD_CYC)));
  assign wr_cmd = cke_i && (cmd_i == CMD_WR) && (state == DBS_ACTIVE
                  || (state == DBS_EXIT && exit_cnt >= 16'(TXSNR_CYC)));

  // Flag any command that breaks a condition the controller must keep.
  always_comb begin
    bad_cmd = 1'b0;
    if ((rd_cmd || wr_cmd) && !bank_open[bank_i]) begin
      bad_cmd = 1'b1;
    end
    // self refresh needs idle banks; termination already off.
    if (state == DBS_ACTIVE && cmd_i == CMD_REF && !cke_i
        && ((|bank_open) || odt_i)) begin
      bad_cmd = 1'b1;
    end
    if (state == DBS_EXIT && cke_i) begin
      if (cmd_i == CMD_RD && exit_cnt < 16'(XSRD_CYC)) begin
        bad_cmd = 1'b1;
      end else if (cmd_i != CMD_RD && cmd_i != CMD_NOP && cmd_i != CMD_DESEL
                   && exit_cnt < 16'(TXSNR_CYC)) begin
        bad_cmd = 1'b1;
      end
      if (odt_i && exit_cnt < 16'(XSRD_CYC)) begin
        bad_cmd = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bank tracking and self refresh state.
  ////////////////////////////////////////////////////////////////////////////////

  // Open on activate, close on precharge.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bank_open <= '0;
    end else if (cke_i && state != DBS_SREF) begin
      if (cmd_i == CMD_ACT) begin
        bank_open[bank_i] <= 1'b1;
      end else if (cmd_i == CMD_PRE) begin
        bank_open[bank_i] <= 1'b0;
      end
    end
  end

  // Refresh with clock enable low enters self refresh; clock enable high leaves.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state    <= DBS_ACTIVE;
      exit_cnt <= '0;
    end else begin
      case (state)
        DBS_ACTIVE: begin
          if (!cke_i && cmd_i == CMD_REF) begin
            state <= DBS_SREF;
          end
        end
        DBS_SREF: begin
          if (cke_i) begin
            // The exit edge itself counts as the first clock of the delay.
            state    <= DBS_EXIT;
            exit_cnt <= 16'h0001;
          end
        end
        DBS_EXIT: begin
          if (exit_cnt >= 16'(XSRD_CYC)) begin
            state <= DBS_ACTIVE;
          end else begin
            exit_cnt <= exit_cnt + 16'h0001;
          end
        end
        default: state <= DBS_ACTIVE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst scheduling lines.
  ////////////////////////////////////////////////////////////////////////////////

  // Each command sets its beats at latency; back to back bursts join seamlessly.
  always_comb begin
    next_rd_line = rd_line >> 1;
    next_wr_line = wr_line >> 1;
    for (int i = 0; i < LAT_DEPTH; i++) begin
      // reads drive beats from read latency; a closed bank gets none.
      if (rd_cmd && bank_open[bank_i]
          && i + 1 >= int'(rl) && i + 1 < int'(rl) + int'(beats)) begin
        next_rd_line[i] = 1'b1;
      end
      // writes take beats from write latency; a closed bank takes none.
      if (wr_cmd && bank_open[bank_i]
          && i + 1 >= int'(wl) && i + 1 < int'(wl) + int'(beats)) begin
        next_wr_line[i] = 1'b1;
      end
    end
  end

  // Shift the lines once per clock.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rd_line <= '0;
      wr_line <= '0;
    end else begin
      rd_line <= next_rd_line;
      wr_line <= next_wr_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data paths.
  ////////////////////////////////////////////////////////////////////////////////

  // accept write data in its window.
  assign f_in.valid    = wr_line[0];
  assign f_in.data     = wdata_i;
  assign wdata_ready_o = f_in.ready;
  assign wr_valid_o    = f_out.valid;
  assign wr_data_o     = f_out.data;
  assign f_out.ready   = wr_ready_i;

  dbs_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .wr        (f_in),
    .rd        (f_out)
  );

  // read data and strobes, continuous across bursts.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
      dqs_o         <= 1'b0;
      dqs_n_o       <= 1'b1;
      dqs_oe_o      <= 1'b0;
    end else begin
      rdata_valid_o <= rd_line[0];
      dqs_oe_o      <= rd_line[0];
      dqs_o         <= rd_line[0];
      // complement strobe only in differential mode.
      dqs_n_o       <= dqs_diff_en_i ? !rd_line[0] : 1'b0;
      if (rd_line[0]) begin
        rdata_o <= array_rdata_i;
      end
    end
  end

  // Status flags.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sref_o       <= 1'b0;
      odt_active_o <= 1'b0;
      cmd_err_o    <= 1'b0;
    end else begin
      sref_o       <= (state == DBS_SREF);
      // termination counts once the long exit delay has run out.
      odt_active_o <= odt_i && (state == DBS_ACTIVE
                      || (state == DBS_EXIT && exit_cnt >= 16'(XSRD_CYC)));
      cmd_err_o    <= bad_cmd;
    end
  end

endmodule : dbs_seq
`default_nettype wire

// File: sim/dbs_seq_checker.sv
// Concurrent checks on the burst and self refresh sequencer ports.
`timescale 1ns/1ns
`default_nettype none
module dbs_seq_checker
  import dbs_pkg::*;
#(
  parameter int unsigned DQ_W     = 16,
  parameter int unsigned XSRD_CYC = 8
) (
  // Clock, reset, command and mode inputs.
  input wire logic              clk_sys_i, nrst_i, cke_i, bl8_i, dqs_diff_en_i, wr_ready_i,
  input wire logic [3:0]        cmd_i, al_i, cl_i,
  input wire logic [BANK_W-1:0] bank_i,
  // Outputs under watch.
  input wire logic              wr_valid_o, rdata_valid_o, dqs_n_o, sref_o,
  input wire logic              odt_active_o, cmd_err_o,
  input wire logic [DQ_W-1:0]   wr_data_o
);
  logic [NUM_BANKS-1:0] open_b;   // Banks activated and not precharged.
  logic [31:0]          rd_hist;  // Accepted reads, newest in bit 0.
  logic [8:0]           exit_cnt; // Cycles since self refresh ended, saturating.
  logic                 exp_rd;   // A read beat is due now.
  wire logic rw  = cke_i && !sref_o && (cmd_i == CMD_RD || cmd_i == CMD_WR);
  wire logic rdt = rw && cmd_i == CMD_RD && open_b[bank_i];

  // Tracks which banks a burst may address.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) open_b <= '0;
    else if (cke_i && cmd_i == CMD_ACT) open_b[bank_i] <= 1'b1;
    else if (cke_i && cmd_i == CMD_PRE) open_b[bank_i] <= 1'b0;
  end

  // Keeps the history of accepted reads for the beat timing.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) rd_hist <= '0;
    else rd_hist <= {rd_hist[30:0], rdt};
  end

  // Counts the cycles since self refresh was left.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) exit_cnt <= 9'(XSRD_CYC);
    else if (sref_o) exit_cnt <= '0;
    else if (exit_cnt < 9'(XSRD_CYC)) exit_cnt <= exit_cnt + 9'h1;
  end

  // A beat is due when a read lies latency plus beat index cycles back.
  always_comb begin
    exp_rd = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (k < (bl8_i ? 4 : 2)) exp_rd = exp_rd | rd_hist[5'(al_i) + 5'(cl_i) + 5'(k)];
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // Entry condition and the steps of a self refresh stay.
  sequence sref_go;
    !sref_o && !cke_i && cmd_i == CMD_REF && open_b == '0;
  endsequence
  sequence sref_stay;
    sref_o && !cke_i;
  endsequence

  rd_beats_a:   assert property (rdata_valid_o == exp_rd)
    else $error("read beat timing wrong");
  err_closed_a: assert property (rw && !open_b[bank_i] |=> cmd_err_o)
    else $error("closed bank access not flagged");
  err_clean_a:  assert property (rw && open_b[bank_i] |=> !cmd_err_o)
    else $error("open bank access flagged");
  sref_enter_a: assert property (sref_go |=> ##1 sref_o)
    else $error("self refresh not entered");
  sref_hold_a:  assert property (sref_stay |=> sref_o)
    else $error("self refresh left while clock enable low");
  odt_sref_a:   assert property (sref_o |-> !odt_active_o)
    else $error("termination on in self refresh");
  odt_exit_a:   assert property (odt_active_o |-> exit_cnt >= 9'(XSRD_CYC - 1))
    else $error("termination back too early");
  dqs_single_a: assert property (!dqs_diff_en_i ##1 !dqs_diff_en_i |-> !dqs_n_o)
    else $error("complement strobe driven in single mode");
  fifo_hold_a:  assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
    else $error("write word not held while stalled");
endmodule : dbs_seq_checker
bind dbs_seq dbs_seq_checker #(.DQ_W(DQ_W), .XSRD_CYC(XSRD_CYC)) chk (.clk_sys_i, .nrst_i,
  .cke_i, .bl8_i, .dqs_diff_en_i, .wr_ready_i, .cmd_i, .al_i, .cl_i, .bank_i, .wr_valid_o,
  .rdata_valid_o, .dqs_n_o, .sref_o, .odt_active_o, .cmd_err_o, .wr_data_o);
`default_nettype wire

// File: sim/dbs_ctrl_model.sv
// Memory controller model that drives the command side of the sequencer.
`timescale 1ns/1ns
`default_nettype none
module dbs_ctrl_model
  import dbs_pkg::*;
#(
  parameter int unsigned XSRD_CYC  = 8,
  parameter int unsigned TAOFD_CYC = 2
) (
  input  wire logic              clk_sys_i,
  output logic                   cke_o = 1'b1,
  output logic [3:0]             cmd_o = CMD_NOP,
  output logic [BANK_W-1:0]      bank_o = '0,
  output logic                   odt_o = 1'b0
);
  logic [NUM_BANKS-1:0] open_b = '0; // Banks this controller has opened.

  // One command, then idle until the next slot.
  task automatic issue(input logic [3:0] c, input logic [BANK_W-1:0] b, input int gap);
    if (c == CMD_ACT) open_b[b] = 1'b1;
    if (c == CMD_PRE) open_b[b] = 1'b0;
    cmd_o  <= c;
    bank_o <= b;
    @(posedge clk_sys_i);
    cmd_o <= CMD_NOP;
    repeat (gap - 1) @(posedge clk_sys_i);
  endtask : issue

  // Closes every bank, drops termination, then enters self refresh.
  task automatic sref_in();
    for (int b = 0; b < NUM_BANKS; b++) if (open_b[b]) issue(CMD_PRE, BANK_W'(b), 2);
    odt_o <= 1'b0;
    repeat (TAOFD_CYC) @(posedge clk_sys_i);
    cke_o <= 1'b0;
    issue(CMD_REF, '0, 1);
  endtask : sref_in

  // Leaves self refresh and waits the longer exit delay before anything else.
  task automatic sref_out();
    cke_o <= 1'b1;
    repeat (XSRD_CYC) @(posedge clk_sys_i);
    odt_o <= 1'b1;
  endtask : sref_out
endmodule : dbs_ctrl_model
`default_nettype wire

// File: sim/ddr2_burst_selfrefresh_seq_tb.sv
// Self-checking bench for the burst and self refresh sequencer.
`timescale 1ns/1ns
`default_nettype none
module ddr2_burst_selfrefresh_seq_tb;
  import dbs_pkg::*;
  localparam int XS = 8;
  logic clk_sys_i = 0, nrst_i = 0, cke, odt, bl8 = 0, ddiff = 1, wr_ready = 0, stall = 0;
  logic [3:0] cmd, al = 4'h2, cl = 4'h3;
  logic [1:0] bank;
  logic [15:0] wdata = 0, ardata = 0, wr_data, rdata;
  logic wdr, wr_valid, rv, dqs, dqsn, dqsoe, sref, odta, err, seen_full = 0;
  int fails = 0, checks_done = 0, cyc = 0, beats = 0, first = 0, last = 0, errs = 0, e0, g;
  logic [31:0] whist = 0;
  logic [15:0] ard_q = 0;
  logic dd_q = 1;
  logic [15:0] expq[$];
  logic [8:0] tbl[4] = '{{4'h2, 4'h3, 1'b0}, {4'h2, 4'h3, 1'b1}, {4'h0, 4'h3, 1'b0},
                          {4'h1, 4'h4, 1'b1}};

  always #25 clk_sys_i = ~clk_sys_i;

  dbs_ctrl_model #(.XSRD_CYC(XS)) ctl (.clk_sys_i, .cke_o(cke), .cmd_o(cmd), .bank_o(bank),
    .odt_o(odt));
  dbs_seq #(.XSRD_CYC(XS)) dut (.clk_sys_i, .nrst_i, .cke_i(cke), .cmd_i(cmd), .bank_i(bank),
    .odt_i(odt), .al_i(al), .cl_i(cl), .bl8_i(bl8), .dqs_diff_en_i(ddiff), .wdata_i(wdata),
    .wdata_ready_o(wdr), .wr_valid_o(wr_valid), .wr_data_o(wr_data), .wr_ready_i(wr_ready),
    .array_rdata_i(ardata), .rdata_o(rdata), .rdata_valid_o(rv), .dqs_o(dqs), .dqs_n_o(dqsn),
    .dqs_oe_o(dqsoe), .sref_o(sref), .odt_active_o(odta), .cmd_err_o(err));

  // Counts one comparison and reports a mismatch.
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // A write word is due when a write lies write latency plus beat cycles back.
  function automatic logic wexp();
    for (int k = 0; k < (bl8 ? 4 : 2); k++) if (whist[al + cl - 2 + k]) return 1'b1;
    return 1'b0;
  endfunction : wexp

  // Drives data inputs, records expectations and watches the outputs.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    wdata <= 16'($urandom);
    ardata <= 16'($urandom);
    wr_ready <= stall ? 1'b0 : 1'($urandom);
    whist <= {whist[30:0], cke === 1'b1 && cmd === CMD_WR && ctl.open_b[bank]};
    ard_q <= ardata;
    dd_q <= ddiff;
    if (nrst_i === 1'b1) begin
      chk("dqs", {13'h0, rv, rv, dd_q & !rv}, {13'h0, dqsoe, dqs, dqsn});
      if (rv === 1'b1) chk("rdata", ard_q, rdata);
    end
    if (wexp() && wdr === 1'b1) expq.push_back(wdata);
    if (wdr === 1'b0) seen_full = 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (expq.size() > 0) chk("wr_data", expq.pop_front(), wr_data);
      else chk("wr_extra", 16'h0, 16'h1);
    end
    if (rv === 1'b1) begin
      if (beats == 0) first = cyc;
      last = cyc;
      beats++;
    end
    if (err === 1'b1) errs++;
    if (cyc > 20000) begin
      fails++;
      print_verdict();
    end
  end

  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'h8581));
    repeat (10) @(posedge clk_sys_i);
    chk("reset_out", 16'h0003, {11'h0, sref, err, rv, dqsn, wdr});
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int b = 0; b < NUM_BANKS; b++) ctl.issue(CMD_ACT, 2'(b), 2);
    // Gapless reads for each of the four latency and burst settings in tbl.
    foreach (tbl[i]) begin
      {al, cl, bl8} <= tbl[i];
      ddiff <= 1'($urandom);
      beats = 0;
      g = tbl[i][0] ? 4 : 2;
      for (int r = 0; r < 3; r++) ctl.issue(CMD_RD, 2'($urandom), g);
      repeat (30) @(posedge clk_sys_i);
      chk("rd_beats", 16'(3 * g), 16'(beats));
      chk("rd_gapless", 16'(3 * g), 16'(last - first + 1));
    end
    // Bursts to a closed bank are refused.
    e0 = errs;
    ctl.issue(CMD_PRE, 2'h2, 2);
    ctl.issue(CMD_RD, 2'h2, 2);
    ctl.issue(CMD_WR, 2'h2, 4);
    chk("cmd_err", 16'(e0 + 2), 16'(errs));
    ctl.issue(CMD_ACT, 2'h2, 2);
    // Gapless writes, then a stalled storm that fills the buffer.
    for (int s = 0; s < 3; s++) begin
      bl8 <= (s == 1);
      stall <= (s == 2);
      for (int w = 0; w < (s == 2 ? 5 : 3); w++) ctl.issue(CMD_WR, 2'($urandom), s == 1 ? 4 : 2);
      repeat (20) @(posedge clk_sys_i);
      stall <= 1'b0;
      repeat (60) @(posedge clk_sys_i);
    end
    chk("fifo_full", 16'h1, {15'h0, seen_full});
    chk("fifo_drain", 16'h0, 16'(expq.size()));
    // Self refresh entry, exit and a read afterwards.
    ddiff <= 1'b0;
    e0 = errs;
    ctl.sref_in();
    repeat (3) @(posedge clk_sys_i);
    chk("sref_in", 16'h0002, {14'h0, sref, odta});
    ctl.sref_out();
    repeat (2) @(posedge clk_sys_i);
    chk("sref_out", 16'h0001, {14'h0, sref, odta});
    ctl.issue(CMD_ACT, 2'h0, 2);
    beats = 0;
    ctl.issue(CMD_RD, 2'h0, 2);
    repeat (20) @(posedge clk_sys_i);
    chk("rd_after_exit", 16'h0002, 16'(beats));
    chk("sref_err", 16'(e0), 16'(errs));
    print_verdict();
  end
endmodule : ddr2_burst_selfrefresh_seq_tb
`default_nettype wire
